// ---- rtl/cdrld_pkg.sv ----
// cdrld_pkg: constants, register map and types of the cdr lock detector.
// assumes a single 100 MHz system clock; no other dependencies.
package cdrld_pkg;
	// register byte addresses on the axi4-lite slave
	localparam int AXI_AW = 4;
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h4;
	localparam logic [3:0] ADDR_CTRL_C = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [7:0] CTRL_C_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// field positions
	localparam int CA_REF_EN = 0;
	localparam int CA_RATIO_LSB = 2;
	localparam int CA_RANGE_LSB = 6;
	localparam int CB_STICKY_CLR = 6;
	localparam int CB_PIN_STICKY = 7;
	localparam int CC_ABSENT_INV = 2;
	localparam int ST_UNLOCKED = 0;
	localparam int ST_ABSENT = 1;
	localparam int ST_HARMONIC = 2;
	localparam int ST_REF_MODE = 3;
	localparam int ST_STICKY = 4;
	localparam int ST_CODE_LSB = 16;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int ABSENT_SET_NS = 500;
	localparam int ABSENT_CLR_NS = 400;
	localparam int ABSENT_SET_CYC = (ABSENT_SET_NS * CLK_MHZ + 999) / 1000;
	localparam int ABSENT_CLR_CYC = (ABSENT_CLR_NS * CLK_MHZ + 999) / 1000;
	localparam int ABS_W = 7;
	// frequency error limits
	localparam int PPM_FULL = 1000000;
	localparam int LOSE_PPM = 1000;
	localparam int LOCK_PPM = 250;
	// oscillator model and measurement
	localparam int NCO_W = 20;
	localparam int CODE_W = 16;
	localparam int CNT_W = 24;
	localparam logic [15:0] OSC_MIN_CODE = 16'h0100;
	localparam logic [15:0] OSC_MAX_CODE = 16'hFFFF;
	localparam logic [15:0] STEP_MAX = 16'h1000;
	localparam int DENS_SHIFT = 1;
	localparam int MEAS_CYC_DEF = 65536;
	localparam int HARM_EXP = 16;
	localparam int HARM_TICKS_DEF = 2 ** (HARM_EXP + DENS_SHIFT);
	localparam int HARM_CNT_W = 18;
	typedef enum logic [0:0] {CDRLD_ACQ, CDRLD_LOCK} cdrld_state_t;
endpackage

// ---- rtl/cdrld_reg_if.sv ----
// cdrld_reg_if: control fields and status between register slave and core.
// assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface cdrld_reg_if;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] ctrl_c;
	logic sticky_clr;
	logic [31:0] status;
	modport regs (output ctrl_a, output ctrl_b, output ctrl_c, output sticky_clr, input status);
	modport core (input ctrl_a, input ctrl_b, input ctrl_c, input sticky_clr, output status);
endinterface

// ---- rtl/cdrld_freq_meter.sv ----
// cdrld_freq_meter: counts oscillator and target events over a fixed window.
// assumes one-cycle tick inputs on the system clock.
`timescale 1ns/1ps
module cdrld_freq_meter import cdrld_pkg::*; #(
	parameter int MEAS_CYC = MEAS_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// events
	input wire logic osc_tick,
	input wire logic data_edge,
	input wire logic ref_rise,
	input wire logic ref_mode,
	input wire logic [1:0] range,
	input wire logic [3:0] ratio,
	// results
	output logic done,
	output logic [CNT_W-1:0] osc_cnt,
	output logic [CNT_W-1:0] tgt_cnt
);
	logic [CNT_W-1:0] win;
	logic [CNT_W-1:0] osc_acc;
	logic [CNT_W-1:0] tgt_acc;
	logic [31:0] ref_scaled;
	logic tgt_tick;
	logic win_end;

	assign tgt_tick = ref_mode ? ref_rise : data_edge;
	assign win_end = (win == CNT_W'(MEAS_CYC - 1));
	// data rate / 2^ratio = reference / 2^range; counts beyond 32 bits wrap
	assign ref_scaled = ({8'h00, tgt_acc} << ratio) >> range;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win <= '0;
			osc_acc <= '0;
			tgt_acc <= '0;
			osc_cnt <= '0;
			tgt_cnt <= '0;
			done <= 1'b0;
		end else if (win_end) begin
			win <= '0;
			osc_acc <= CNT_W'(osc_tick);
			tgt_acc <= CNT_W'(tgt_tick);
			osc_cnt <= osc_acc;
			// transitions to bits assumes half transition density
			tgt_cnt <= ref_mode ? ref_scaled[CNT_W-1:0] : (tgt_acc << DENS_SHIFT);
			done <= 1'b1;
		end else begin
			win <= win + 1'b1;
			osc_acc <= osc_acc + CNT_W'(osc_tick);
			tgt_acc <= tgt_acc + CNT_W'(tgt_tick);
			done <= 1'b0;
		end
	end
endmodule

// ---- rtl/cdrld_axil_regs.sv ----
// cdrld_axil_regs: axi4-lite slave holding the three control registers.
// assumes the core drives status through the interface; one clock.
`timescale 1ns/1ps
module cdrld_axil_regs import cdrld_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write channels
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core side
	cdrld_reg_if.regs rif
);
	logic aw_held;
	logic w_held;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
		return a == ADDR_CTRL_A || a == ADDR_CTRL_B || a == ADDR_CTRL_C || a == ADDR_STATUS;
	endfunction

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rif.ctrl_a <= CTRL_A_RST;
			rif.ctrl_b <= CTRL_B_RST;
			rif.ctrl_c <= CTRL_C_RST;
			rif.sticky_clr <= 1'b0;
		end else begin
			// clear fires on the one-then-zero sequence of the clear bit
			rif.sticky_clr <= do_write && w_strb[0] && aw_addr == ADDR_CTRL_B &&
				rif.ctrl_b[CB_STICKY_CLR] && !w_data[CB_STICKY_CLR];
			if (do_write && w_strb[0]) begin
				if (aw_addr == ADDR_CTRL_A) rif.ctrl_a <= w_data[7:0];
				if (aw_addr == ADDR_CTRL_B) rif.ctrl_b <= w_data[7:0];
				if (aw_addr == ADDR_CTRL_C) rif.ctrl_c <= w_data[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				ADDR_CTRL_A: s_axi_rdata <= {24'h000000, rif.ctrl_a};
				ADDR_CTRL_B: s_axi_rdata <= {24'h000000, rif.ctrl_b};
				ADDR_CTRL_C: s_axi_rdata <= {24'h000000, rif.ctrl_c};
				ADDR_STATUS: s_axi_rdata <= rif.status;
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- rtl/cdrld_top.sv ----
// cdrld_top: lock supervision, frequency acquisition, harmonic and input-absent detection.
// assumes serial data, reference clock and level codes arrive asynchronously.
`timescale 1ns/1ps
module cdrld_top import cdrld_pkg::*; #(
	parameter int MEAS_CYC = MEAS_CYC_DEF,
	parameter int HARM_TICKS = HARM_TICKS_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// axi4-lite write
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// front-end inputs
	input wire logic rx_data,
	input wire logic aux_reference_clock,
	input wire logic [7:0] rx_level,
	input wire logic [7:0] threshold_set_pin,
	input wire logic [7:0] slice_offset_inputs,
	// lock and signal indications
	output logic unlocked_flag,
	output logic input_absent_flag,
	output logic fll_enable,
	output logic pll_track_enable,
	// oscillator and quantizer control
	output logic [CODE_W-1:0] osc_freq_code,
	output logic [7:0] slice_level
);
	localparam int SYNC_W = 26;

	cdrld_reg_if rif();

	logic rst_meta_n;
	logic rst_core_n;
	logic [SYNC_W-1:0] pin_meta;
	logic [SYNC_W-1:0] pin_sync;
	logic data_s;
	logic ref_s;
	logic [7:0] level_s;
	logic [7:0] thr_s;
	logic data_d;
	logic ref_d;
	logic data_edge;
	logic ref_rise;
	logic ref_mode;
	logic [NCO_W-1:0] nco_acc;
	logic [NCO_W:0] nco_sum;
	logic osc_tick;
	logic meas_done;
	logic [CNT_W-1:0] osc_cnt;
	logic [CNT_W-1:0] tgt_cnt;
	logic too_far;
	logic close;
	cdrld_state_t state;
	logic [CODE_W-1:0] step;
	logic harm_hit;
	logic harm_seen;
	logic lock_lost;
	logic sticky;
	logic [1:0] run_len;
	logic saw_single;
	logic [HARM_CNT_W-1:0] harm_cnt;
	logic below;
	logic above;
	logic absent;
	logic [ABS_W-1:0] abs_tmr;

	// true when counts differ by more than ppm of target
	function automatic logic beyond_ppm(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b,
		input int ppm);
		logic [CNT_W-1:0] diff;
		logic [CNT_W+20:0] lhs;
		logic [CNT_W+20:0] rhs;
		diff = (a > b) ? a - b : b - a;
		lhs = (CNT_W+21)'(diff) * (CNT_W+21)'(PPM_FULL);
		rhs = (CNT_W+21)'(b) * (CNT_W+21)'(ppm);
		return lhs > rhs;
	endfunction

	// async assert, synchronous release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_core_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_core_n <= rst_meta_n;
		end
	end

	// level and threshold codes assumed slow against the clock
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {rx_data, aux_reference_clock, rx_level, threshold_set_pin,
				slice_offset_inputs};
			pin_sync <= pin_meta;
		end
	end
	assign data_s = pin_sync[25];
	assign ref_s = pin_sync[24];
	assign level_s = pin_sync[23:16];
	assign thr_s = pin_sync[15:8];

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			data_d <= 1'b0;
			ref_d <= 1'b0;
			slice_level <= '0;
		end else begin
			data_d <= data_s;
			ref_d <= ref_s;
			slice_level <= pin_sync[7:0];
		end
	end
	assign data_edge = data_s ^ data_d;
	assign ref_rise = ref_s & ~ref_d;
	assign ref_mode = rif.ctrl_a[CA_REF_EN];

	// oscillator model: one tick per recovered bit period
	assign nco_sum = {1'b0, nco_acc} + (NCO_W+1)'(osc_freq_code);
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			nco_acc <= '0;
			osc_tick <= 1'b0;
		end else begin
			nco_acc <= nco_sum[NCO_W-1:0];
			osc_tick <= nco_sum[NCO_W];
		end
	end

	// range and ratio reset to zero, the lowest range
	cdrld_freq_meter #(.MEAS_CYC(MEAS_CYC)) u_meter (
		.clk(sys_clk),
		.rst_n(rst_core_n),
		.osc_tick(osc_tick),
		.data_edge(data_edge),
		.ref_rise(ref_rise),
		.ref_mode(ref_mode),
		.range(rif.ctrl_a[CA_RANGE_LSB +: 2]),
		.ratio(rif.ctrl_a[CA_RATIO_LSB +: 4]),
		.done(meas_done),
		.osc_cnt(osc_cnt),
		.tgt_cnt(tgt_cnt)
	);

	assign too_far = beyond_ppm(osc_cnt, tgt_cnt, LOSE_PPM);
	assign close = !beyond_ppm(osc_cnt, tgt_cnt, LOCK_PPM);
	assign lock_lost = state == CDRLD_LOCK && ((meas_done && too_far) || harm_hit);

	// acquisition sequencer; no reference needed in normal mode
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			state <= CDRLD_ACQ;
			osc_freq_code <= OSC_MIN_CODE;
			step <= STEP_MAX;
		end else begin
			case (state)
				CDRLD_LOCK: begin
					if (lock_lost) begin
						state <= CDRLD_ACQ;
						step <= STEP_MAX;
						if (!ref_mode) osc_freq_code <= OSC_MIN_CODE;
					end
				end
				CDRLD_ACQ: begin
					if (meas_done) begin
						if (close) begin
							state <= CDRLD_LOCK;
						end else if (osc_cnt < tgt_cnt) begin
							osc_freq_code <= (osc_freq_code > OSC_MAX_CODE - step) ?
								OSC_MAX_CODE : osc_freq_code + step;
						end else begin
							osc_freq_code <= (osc_freq_code < OSC_MIN_CODE + step) ?
								OSC_MIN_CODE : osc_freq_code - step;
							if (step > CODE_W'(1)) step <= step >> 1;
						end
					end
				end
				default: state <= CDRLD_ACQ;
			endcase
		end
	end

	// lower harmonic: no single-bit run seen within the window
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			run_len <= '0;
			saw_single <= 1'b0;
			harm_cnt <= '0;
			harm_hit <= 1'b0;
		end else if (state != CDRLD_LOCK || ref_mode) begin
			run_len <= '0;
			saw_single <= 1'b0;
			harm_cnt <= '0;
			harm_hit <= 1'b0;
		end else begin
			if (data_edge) begin
				if (run_len < 2'd2) saw_single <= 1'b1;
				run_len <= '0;
			end else if (osc_tick && run_len != 2'd3) begin
				run_len <= run_len + 1'b1;
			end
			harm_hit <= 1'b0;
			if (osc_tick) begin
				if (harm_cnt == HARM_CNT_W'(HARM_TICKS - 1)) begin
					harm_cnt <= '0;
					saw_single <= 1'b0;
					harm_hit <= !saw_single;
				end else begin
					harm_cnt <= harm_cnt + 1'b1;
				end
			end
		end
	end

	// sticky loss bit: a loss in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			sticky <= 1'b0;
			harm_seen <= 1'b0;
		end else begin
			if (lock_lost) sticky <= 1'b1;
			else if (rif.sticky_clr) sticky <= 1'b0;
			if (harm_hit) harm_seen <= 1'b1;
			else if (rif.sticky_clr) harm_seen <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			unlocked_flag <= 1'b1;
			fll_enable <= 1'b1;
			pll_track_enable <= 1'b0;
		end else begin
			unlocked_flag <= rif.ctrl_b[CB_PIN_STICKY] ? sticky : (state == CDRLD_ACQ);
			fll_enable <= state == CDRLD_ACQ;
			pll_track_enable <= state == CDRLD_LOCK;
		end
	end

	// input absent: level only, slice offset never enters here
	assign below = level_s < thr_s;
	assign above = {1'b0, level_s} >= {thr_s, 1'b0};
	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			absent <= 1'b0;
			abs_tmr <= '0;
		end else if (absent ? above : below) begin
			if (abs_tmr == ABS_W'((absent ? ABSENT_CLR_CYC : ABSENT_SET_CYC) - 1)) begin
				absent <= ~absent;
				abs_tmr <= '0;
			end else begin
				abs_tmr <= abs_tmr + 1'b1;
			end
		end else begin
			abs_tmr <= '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_core_n) begin
		if (!rst_core_n) input_absent_flag <= 1'b0;
		else input_absent_flag <= absent ^ rif.ctrl_c[CC_ABSENT_INV];
	end

	always_comb begin
		rif.status = '0;
		rif.status[ST_UNLOCKED] = state == CDRLD_ACQ;
		rif.status[ST_ABSENT] = absent;
		rif.status[ST_HARMONIC] = harm_seen;
		rif.status[ST_REF_MODE] = ref_mode;
		rif.status[ST_STICKY] = sticky;
		rif.status[ST_CODE_LSB +: CODE_W] = osc_freq_code;
	end

	cdrld_axil_regs u_regs (
		.clk(sys_clk),
		.rst_n(rst_core_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif)
	);

	a_lose_to_acq: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		state == CDRLD_LOCK && meas_done && too_far |=> state == CDRLD_ACQ ##1 fll_enable)
		else $error("lock loss did not restart acquisition");
	a_restart_bottom: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		lock_lost && !ref_mode |=> osc_freq_code == OSC_MIN_CODE)
		else $error("normal acquisition did not start at bottom");
	a_ref_keeps_code: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		lock_lost && ref_mode |=> osc_freq_code == $past(osc_freq_code))
		else $error("reference relock swept the oscillator");
	a_step_halves: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		state == CDRLD_ACQ && meas_done && !close && osc_cnt >= tgt_cnt && step > 16'h0001
		|=> step == ($past(step) >> 1))
		else $error("step did not shrink on overshoot");
	a_lock_when_close: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		$rose(state == CDRLD_LOCK) |-> $past(meas_done && close))
		else $error("lock declared outside the clear limit");
	a_loop_handover: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		state == CDRLD_LOCK |=> pll_track_enable && !fll_enable)
		else $error("frequency loop not handed over on lock");
	a_sticky_holds: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		sticky && !rif.sticky_clr |=> sticky)
		else $error("sticky loss bit dropped without a clear");
	a_pin_mirror: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		rif.ctrl_b[CB_PIN_STICKY] |=> unlocked_flag == $past(sticky))
		else $error("unlocked pin does not mirror sticky bit");
	a_harm_off_ref: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		ref_mode |=> !harm_hit)
		else $error("harmonic detector active in reference mode");
	a_absent_delay: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		$rose(absent) |-> $past(abs_tmr) == ABS_W'(ABSENT_SET_CYC - 1) && $past(below))
		else $error("input absent asserted without full delay");
	a_absent_hyst: assert property (@(posedge sys_clk) disable iff (!rst_core_n)
		absent && !above |=> absent)
		else $error("input absent released below twice threshold");
endmodule

// ---- sim/cdrld_data_src.sv ----
// cdrld_data_src: serial nrz data source standing in for the optical front end.
// assumes bit_cyc is a whole number of system clocks per bit, at least 2.
`timescale 1ns/1ps
module cdrld_data_src (
	// clock
	input wire logic clk,
	// bit period in clocks
	input wire logic [15:0] bit_cyc,
	// serial line
	output logic rx_data
);
	logic [15:0] cnt = 16'h0000;
	logic [1:0] idx = 2'h0;
	// repeating 1,0,1,1: half the boundaries toggle and one-bit runs occur
	always_ff @(posedge clk) begin
		if (cnt >= bit_cyc - 16'h0001) begin
			cnt <= 16'h0000;
			idx <= idx + 2'h1;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
	assign rx_data = (idx != 2'h1);
endmodule

// ---- sim/cdr_lock_detector_bench.sv ----
// cdr_lock_detector_bench: self-checking bench of the lock detector top.
// assumes a short measurement window of 4096 clocks so lock comes quickly.
`timescale 1ns/1ps
module cdr_lock_detector_bench import cdrld_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, aux_reference_clock = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic rx_data, unlocked_flag, input_absent_flag, fll_enable, pll_track_enable;
	logic [15:0] osc_freq_code, bit_cyc = 16'h0100;
	logic [7:0] rx_level = 8'h40, threshold_set_pin = 8'h20, slice_offset_inputs = 8'hFF;
	logic [7:0] slice_level;
	int mismatches = 0, checks = 0;

	always #5 sys_clk = ~sys_clk;

	cdrld_top #(.MEAS_CYC(4096), .HARM_TICKS(64)) i_cdrld_top (
		.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data, .aux_reference_clock,
		.rx_level, .threshold_set_pin, .slice_offset_inputs, .unlocked_flag,
		.input_absent_flag, .fll_enable, .pll_track_enable, .osc_freq_code, .slice_level
	);
	cdrld_data_src i_cdrld_data_src (.clk(sys_clk), .bit_cyc(bit_cyc), .rx_data(rx_data));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// handshakes judged at the rising edge, before that edge's updates land
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic test_done;
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (2) @(negedge sys_clk);
		chk("unlocked", unlocked_flag, 1);
		chk("code", osc_freq_code, 16'h0100);
		chk("fll", fll_enable, 1);
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		axr(ADDR_CTRL_A);
		chk("ctrl_a", rd, 32'h0);
		axw(ADDR_CTRL_A, 32'hFC);
		axr(ADDR_CTRL_A);
		chk("ctrl_a fields", rd, 32'hFC);
		axw(ADDR_CTRL_A, 32'h0);
		axr(4'h2);
		chk("unmapped", rs, RESP_SLVERR);
		// absent after about 500 ns below threshold, not before
		@(posedge sys_clk);
		rx_level <= 8'h10;
		repeat (40) @(negedge sys_clk);
		chk("absent early", input_absent_flag, 0);
		repeat (25) @(negedge sys_clk);
		chk("absent set", input_absent_flag, 1);
		@(posedge sys_clk);
		rx_level <= 8'h30;
		repeat (100) @(negedge sys_clk);
		chk("absent hyst", input_absent_flag, 1);
		@(posedge sys_clk);
		rx_level <= 8'h40;
		repeat (30) @(negedge sys_clk);
		chk("absent hold", input_absent_flag, 1);
		repeat (30) @(negedge sys_clk);
		chk("absent clear", input_absent_flag, 0);
		axw(ADDR_CTRL_C, 32'h4);
		repeat (5) @(negedge sys_clk);
		chk("absent inv", input_absent_flag, 1);
		axw(ADDR_CTRL_C, 32'h0);
		// normal mode, no reference: lock to the data rate
		wait (unlocked_flag === 1'b0);
		repeat (2) @(negedge sys_clk);
		chk("pll", pll_track_enable, 1);
		chk("fll off", fll_enable, 0);
		axw(ADDR_CTRL_B, 32'h40);
		axw(ADDR_CTRL_B, 32'h0);
		axr(ADDR_STATUS);
		chk("sticky clr", rd[ST_STICKY], 0);
		chk("live lock", rd[ST_UNLOCKED], 0);
		axw(ADDR_CTRL_B, 32'h80);
		repeat (3) @(negedge sys_clk);
		chk("mirror low", unlocked_flag, 0);
		// doubling the data rate must drop lock through frequency error
		@(posedge sys_clk);
		bit_cyc <= 16'h0080;
		wait (unlocked_flag === 1'b1);
		repeat (2) @(negedge sys_clk);
		chk("restart", osc_freq_code, 16'h0100);
		chk("fll on", fll_enable, 1);
		axr(ADDR_STATUS);
		chk("sticky set", rd[ST_STICKY], 1);
		axw(ADDR_CTRL_B, 32'hC0);
		axw(ADDR_CTRL_B, 32'h0);
		repeat (3) @(negedge sys_clk);
		chk("live pin", unlocked_flag, 1);
		axr(ADDR_STATUS);
		chk("sticky reclr", rd[ST_STICKY], 0);
		test_done();
	end
endmodule
